// ==== verilog/bca_pkg.sv ====
package bca_pkg;

    // data path widths
    localparam int DATA_W  = 8;
    localparam int INSTR_W = 12;
    localparam int FADDR_W = 5;
    localparam int PC_W    = 11;
    localparam int PAGE_W  = 2;
    localparam int BSEL_W  = 3;
    localparam int NIB_W   = 4;
    localparam int BUS_AW  = 4;

    // four clocks make one instruction cycle
    localparam logic [1:0] PH_Q1   = 2'h0;
    localparam logic [1:0] PH_Q2   = 2'h1;
    localparam logic [1:0] PH_Q3   = 2'h2;
    localparam logic [1:0] PH_Q4   = 2'h3;
    localparam logic [1:0] PH_STEP = 2'h1;

    // instruction field positions
    localparam int OPC6_LO  = 6;
    localparam int OPC4_LO  = 8;
    localparam int OPC3_LO  = 9;
    localparam int DIRL_LO  = 3;
    localparam int DEST_BIT = 5;
    localparam int BSEL_LO  = 5;
    localparam int BSEL_HI  = 7;
    localparam int LIT_HI   = 7;
    localparam int JUMP_HI  = 8;

    // opcode patterns
    localparam logic [5:0]  OPC_ADD_ACC_FILE = 6'h07;
    localparam logic [5:0]  OPC_AND_ACC_FILE = 6'h05;
    localparam logic [3:0]  OPC_BIT_CLEAR    = 4'h4;
    localparam logic [3:0]  OPC_BIT_SET      = 4'h5;
    localparam logic [3:0]  OPC_SKIP_CLEAR   = 4'h6;
    localparam logic [3:0]  OPC_SKIP_SET     = 4'h7;
    localparam logic [3:0]  OPC_AND_LITERAL  = 4'hE;
    localparam logic [2:0]  OPC_ABS_JUMP     = 3'h5;
    localparam logic [11:0] OPC_CLEAR_ACC    = 12'h040;
    localparam logic [8:0]  OPC_DIR_LOAD     = 9'h000;
    localparam logic [2:0]  DIR_SEL_PORT_A   = 3'h6;

    // file register addresses
    localparam logic [4:0] ADDR_TIMER  = 5'h01;
    localparam logic [4:0] ADDR_PC_LOW = 5'h02;
    localparam logic [4:0] ADDR_PORT_A = 5'h05;
    localparam logic [4:0] ADDR_PORT_B = 5'h06;
    localparam logic [4:0] ADDR_PORT_C = 5'h07;

    // software register map and flag layout
    localparam logic [3:0] REG_ACC   = 4'h0;
    localparam logic [3:0] REG_FLAGS = 4'h1;
    localparam logic [3:0] REG_DIR   = 4'h2;
    localparam logic [3:0] REG_STATE = 4'h3;
    localparam int FLG_CARRY = 0;
    localparam int FLG_DC    = 1;
    localparam int FLG_ZERO  = 2;

    // reset values and constants
    localparam logic [7:0]  RST_DIR  = 8'hFF;
    localparam logic [7:0]  BYTE_0   = 8'h00;
    localparam logic [7:0]  BIT_ONE  = 8'h01;

    typedef enum logic [3:0] {
        OP_NOP, OP_ADD_ACC_FILE, OP_AND_ACC_FILE, OP_AND_LITERAL, OP_BIT_CLEAR, OP_BIT_SET,
        OP_SKIP_CLEAR, OP_SKIP_SET, OP_CLEAR_ACC, OP_DIR_LOAD, OP_ABS_JUMP
    } bca_op_t;

endpackage

// ==== verilog/bca_decode.sv ====
`timescale 1ns/1ps
module bca_decode import bca_pkg::*; (
    // instruction in, operation out
    input  logic [INSTR_W-1:0] ir,
    output bca_op_t            op
);

    // unlisted encodings fall through to a no-operation
    always_comb begin
        op = OP_NOP;
        if (ir[INSTR_W-1:OPC6_LO] == OPC_ADD_ACC_FILE) begin
            op = OP_ADD_ACC_FILE;
        end else if (ir[INSTR_W-1:OPC6_LO] == OPC_AND_ACC_FILE) begin
            op = OP_AND_ACC_FILE;
        end else if (ir[INSTR_W-1:OPC4_LO] == OPC_BIT_CLEAR) begin
            op = OP_BIT_CLEAR;
        end else if (ir[INSTR_W-1:OPC4_LO] == OPC_BIT_SET) begin
            op = OP_BIT_SET;
        end else if (ir[INSTR_W-1:OPC4_LO] == OPC_SKIP_CLEAR) begin
            op = OP_SKIP_CLEAR;
        end else if (ir[INSTR_W-1:OPC4_LO] == OPC_SKIP_SET) begin
            op = OP_SKIP_SET;
        end else if (ir[INSTR_W-1:OPC4_LO] == OPC_AND_LITERAL) begin
            op = OP_AND_LITERAL;
        end else if (ir == OPC_CLEAR_ACC) begin
            op = OP_CLEAR_ACC;
        end else if (ir[INSTR_W-1:DIRL_LO] == OPC_DIR_LOAD && ir[DIRL_LO-1:0] == DIR_SEL_PORT_A) begin
            op = OP_DIR_LOAD;
        end else if (ir[INSTR_W-1:OPC3_LO] == OPC_ABS_JUMP) begin
            op = OP_ABS_JUMP;
        end
    end

endmodule

// ==== verilog/bca_alu.sv ====
`timescale 1ns/1ps
module bca_alu import bca_pkg::*; (
    // operation and operands
    input  bca_op_t           op,
    input  logic [DATA_W-1:0] acc,
    input  logic [DATA_W-1:0] opnd,
    input  logic [DATA_W-1:0] lit,
    input  logic [BSEL_W-1:0] bsel,
    // result and flags
    output logic [DATA_W-1:0] result,
    output logic              carry,
    output logic              dcarry,
    output logic              zero,
    output logic              bit_val
);

    logic [DATA_W:0]   sum;
    logic [NIB_W:0]    low_sum;
    logic [DATA_W-1:0] mask;

    // separate adders for the two carries; dc comes from the low nibble alone
    always_comb begin
        sum     = {1'b0, acc} + {1'b0, opnd};
        low_sum = {1'b0, acc[NIB_W-1:0]} + {1'b0, opnd[NIB_W-1:0]};
        mask    = BIT_ONE << bsel;
        carry   = sum[DATA_W];
        dcarry  = low_sum[NIB_W];
        unique case (op)
            OP_ADD_ACC_FILE: result = sum[DATA_W-1:0];
            OP_AND_ACC_FILE: result = acc & opnd;
            OP_AND_LITERAL:  result = acc & lit;
            OP_BIT_CLEAR:    result = opnd & ~mask;
            OP_BIT_SET:      result = opnd | mask;
            OP_CLEAR_ACC:    result = BYTE_0;
            default:         result = opnd;
        endcase
        zero    = (result == BYTE_0);
        bit_val = |(opnd & mask);
    end

endmodule

// ==== verilog/bca_exec.sv ====
`timescale 1ns/1ps
module bca_exec import bca_pkg::*; (
    // clock, reset, enable
    input  logic               clk,
    input  logic               sys_rst,
    input  logic               ce,
    // fetch stage
    input  logic [INSTR_W-1:0] instr_word,
    input  logic               instr_valid,
    input  logic [PAGE_W-1:0]  page_sel,
    output logic [1:0]         instr_phase,
    output logic               fetch_flush,
    output logic               pc_load,
    output logic [PC_W-1:0]    pc_target,
    // file register space
    output logic [FADDR_W-1:0] file_addr,
    input  logic [DATA_W-1:0]  file_rdata,
    output logic               file_we,
    output logic [DATA_W-1:0]  file_wdata,
    // port pins and direction
    input  logic [DATA_W-1:0]  port_a_pins,
    input  logic [DATA_W-1:0]  port_b_pins,
    input  logic [DATA_W-1:0]  port_c_pins,
    output logic [DATA_W-1:0]  first_io_port_direction_latch_load,
    // timer prescaler
    input  logic               prescaler_on_timer,
    output logic               prescaler_clr,
    // status flags
    output logic               carry_flag,
    output logic               digit_carry_flag,
    output logic               zero_flag,
    // software register port
    input  logic [BUS_AW-1:0]  bus_addr,
    input  logic [DATA_W-1:0]  bus_wdata,
    input  logic               bus_wr,
    input  logic               bus_rd,
    output logic [DATA_W-1:0]  bus_rdata
);

    logic [INSTR_W-1:0] ir;
    logic               ir_live;
    logic               skip_pending;
    logic               jump_load;
    bca_op_t            op;
    logic [DATA_W-1:0]  acc;
    logic [DATA_W-1:0]  opnd;
    logic [DATA_W-1:0]  result;
    logic               res_c;
    logic               res_dc;
    logic               res_z;
    logic               res_bit;
    logic [DATA_W-1:0]  alu_result;
    logic               alu_c;
    logic               alu_dc;
    logic               alu_z;
    logic               alu_bit;
    logic [DATA_W:0]    add_chk;
    logic               commit;
    logic               dest_file;
    logic               writes_acc;
    logic               skip_taken;
    logic               pcl_write;
    logic               bus_we;
    logic               bus_re;

    bca_decode u_decode (
        .ir (ir),
        .op (op)
    );

    bca_alu u_alu (
        .op      (op),
        .acc     (acc),
        .opnd    (opnd),
        .lit     (ir[LIT_HI:0]),
        .bsel    (ir[BSEL_HI:BSEL_LO]),
        .result  (alu_result),
        .carry   (alu_c),
        .dcarry  (alu_dc),
        .zero    (alu_z),
        .bit_val (alu_bit)
    );

    // commit happens in the last clock of the instruction cycle
    assign commit     = ce && instr_phase == PH_Q4 && ir_live;
    assign dest_file  = ((op == OP_ADD_ACC_FILE || op == OP_AND_ACC_FILE) && ir[DEST_BIT])
                        || op == OP_BIT_CLEAR || op == OP_BIT_SET;
    assign writes_acc = ((op == OP_ADD_ACC_FILE || op == OP_AND_ACC_FILE) && !ir[DEST_BIT])
                        || op == OP_AND_LITERAL || op == OP_CLEAR_ACC;
    assign skip_taken = (op == OP_SKIP_CLEAR && !res_bit)
                        || (op == OP_SKIP_SET && res_bit);
    assign pcl_write  = dest_file && file_addr == ADDR_PC_LOW;
    assign bus_we     = ce && bus_wr;
    assign bus_re     = ce && bus_rd;
    assign add_chk    = {1'b0, acc} + {1'b0, opnd};

    // phase counter, advances on each clock with ce high and wraps every four
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            instr_phase <= PH_Q1;
        end else if (ce) begin
            instr_phase <= instr_phase + PH_STEP;
        end
    end

    // capture the instruction; a pending skip turns it into a no-operation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ir        <= '0;
            ir_live   <= 1'b0;
            file_addr <= '0;
        end else if (ce && instr_phase == PH_Q1) begin
            ir        <= instr_word;
            ir_live   <= instr_valid && !skip_pending;
            file_addr <= instr_word[FADDR_W-1:0];
        end
    end

    // the skip request is raised in Q4 and consumed in the next Q1, never both at once
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            skip_pending <= 1'b0;
        end else if (ce) begin
            if (commit && (skip_taken || pcl_write || op == OP_ABS_JUMP)) begin
                skip_pending <= 1'b1;
            end else if (instr_phase == PH_Q1) begin
                skip_pending <= 1'b0;
            end
        end
    end

    // operand fetch: ports read their pins so floating inputs write back as seen
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opnd <= BYTE_0;
        end else if (ce && instr_phase == PH_Q2) begin
            unique case (file_addr)
                ADDR_PORT_A: opnd <= port_a_pins;
                ADDR_PORT_B: opnd <= port_b_pins;
                ADDR_PORT_C: opnd <= port_c_pins;
                default:     opnd <= file_rdata;
            endcase
        end
    end

    // result and flags held for the commit clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result  <= BYTE_0;
            res_c   <= 1'b0;
            res_dc  <= 1'b0;
            res_z   <= 1'b0;
            res_bit <= 1'b0;
        end else if (ce && instr_phase == PH_Q3) begin
            result  <= alu_result;
            res_c   <= alu_c;
            res_dc  <= alu_dc;
            res_z   <= alu_z;
            res_bit <= alu_bit;
        end
    end

    // accumulator: a software write in the commit clock wins over the instruction
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc <= BYTE_0;
        end else if (bus_we && bus_addr == REG_ACC) begin
            acc <= bus_wdata;
        end else if (commit && writes_acc) begin
            acc <= result;
        end
    end

    // flags: bit ops, skips, jumps and direction loads leave them alone
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            carry_flag       <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero_flag        <= 1'b0;
        end else if (bus_we && bus_addr == REG_FLAGS) begin
            carry_flag       <= bus_wdata[FLG_CARRY];
            digit_carry_flag <= bus_wdata[FLG_DC];
            zero_flag        <= bus_wdata[FLG_ZERO];
        end else if (commit) begin
            if (op == OP_ADD_ACC_FILE) begin
                carry_flag       <= res_c;
                digit_carry_flag <= res_dc;
            end
            if (op == OP_ADD_ACC_FILE || op == OP_AND_ACC_FILE || op == OP_AND_LITERAL
                || op == OP_CLEAR_ACC) begin
                zero_flag <= res_z;
            end
        end
    end

    // file write-back strobe, one clock per committing instruction with a file destination
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            file_we    <= 1'b0;
            file_wdata <= BYTE_0;
        end else if (ce) begin
            file_we <= commit && dest_file;
            if (commit) begin
                file_wdata <= result;
            end
        end
    end

    // direction latches reset to all inputs so nothing drives before software says so
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            first_io_port_direction_latch_load <= RST_DIR;
        end else if (commit && op == OP_DIR_LOAD) begin
            first_io_port_direction_latch_load <= acc;
        end
    end

    // prescaler clear when the timer register is rewritten while the prescaler belongs to the timer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prescaler_clr <= 1'b0;
        end else if (ce) begin
            prescaler_clr <= commit && dest_file && file_addr == ADDR_TIMER
                             && prescaler_on_timer;
        end
    end

    // counter load and discard of the prefetched word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc_load     <= 1'b0;
            jump_load   <= 1'b0;
            fetch_flush <= 1'b0;
            pc_target   <= '0;
        end else if (ce) begin
            pc_load     <= commit && (pcl_write || op == OP_ABS_JUMP);
            jump_load   <= commit && op == OP_ABS_JUMP;
            fetch_flush <= commit && (skip_taken || pcl_write || op == OP_ABS_JUMP);
            if (commit && op == OP_ABS_JUMP) begin
                pc_target <= {page_sel, ir[JUMP_HI:0]};
            end else if (commit && pcl_write) begin
                pc_target <= {page_sel, 1'b0, result};
            end
        end
    end

    // read data stands only in the clock after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_rdata <= BYTE_0;
        end else if (ce) begin
            bus_rdata <= BYTE_0;
            if (bus_re) begin
                unique case (bus_addr)
                    REG_ACC:   bus_rdata <= acc;
                    REG_FLAGS: bus_rdata <= {5'h00, zero_flag, digit_carry_flag, carry_flag};
                    REG_DIR:   bus_rdata <= first_io_port_direction_latch_load;
                    REG_STATE: bus_rdata <= {4'h0, skip_pending, ir_live, instr_phase};
                    default:   bus_rdata <= BYTE_0;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    pc_bit8_a: assert property (pc_load && !jump_load |-> !pc_target[JUMP_HI])
        else $error("counter bit 8 not cleared on file write");

    port_pins_a: assert property (ce && instr_phase == PH_Q2 && file_addr == ADDR_PORT_A
        |=> opnd == $past(port_a_pins))
        else $error("port operand not taken from pins");

    direction_latch_load_load_a: assert property (commit && op == OP_DIR_LOAD
        |=> first_io_port_direction_latch_load == $past(acc))
        else $error("direction latches not loaded");

    presc_clear_a: assert property (commit && dest_file && file_addr == ADDR_TIMER
        && prescaler_on_timer |=> prescaler_clr ##1 (!prescaler_clr || !ce))
        else $error("prescaler clear missing");

    add_flags_a: assert property (ce && instr_phase == PH_Q3 && ir_live && op == OP_ADD_ACC_FILE
        ##1 !(bus_we && bus_addr == REG_FLAGS)
        |=> carry_flag == $past(add_chk[DATA_W], 2)
            && zero_flag == ($past(add_chk[DATA_W-1:0], 2) == BYTE_0))
        else $error("add flags wrong");

    dest_route_a: assert property (commit && op == OP_AND_ACC_FILE && ir[DEST_BIT]
        && !bus_we |=> file_we && $stable(acc))
        else $error("destination routing wrong");

    bit_clear_a: assert property (commit && op == OP_BIT_CLEAR && !bus_we
        |=> file_we && !file_wdata[$past(ir[BSEL_HI:BSEL_LO])]
            && $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("bit clear wrong");

    bit_set_a: assert property (commit && op == OP_BIT_SET && !bus_we
        |=> file_we && file_wdata[$past(ir[BSEL_HI:BSEL_LO])]
            && $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("bit set wrong");

    and_literal_a: assert property (commit && op == OP_AND_LITERAL && !bus_we
        |=> acc == $past(result) && $stable({carry_flag, digit_carry_flag}))
        else $error("and literal wrong");

    skip_flush_a: assert property (commit && skip_taken ##1 ce[*4]
        |-> !ir_live)
        else $error("skipped instruction executed");

    clear_acc_a: assert property (commit && op == OP_CLEAR_ACC && !bus_we
        |=> acc == BYTE_0 && zero_flag)
        else $error("clear accumulator wrong");

    skip_set_a: assert property (commit && op == OP_SKIP_SET && res_bit && !bus_we
        |=> fetch_flush && $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("skip on set bit missing");

    // zero follows the masked value, carry and digit carry must not move
    and_file_a: assert property (commit && op == OP_AND_ACC_FILE && !bus_we
        |=> zero_flag == ($past(result) == BYTE_0)
            && $stable({carry_flag, digit_carry_flag}))
        else $error("and with file flags wrong");

    // a software write to the accumulator mid-instruction would void the expectation
    add_to_acc_a: assert property (commit && op == OP_ADD_ACC_FILE && !ir[DEST_BIT]
        && !bus_we && $stable(acc) |=> acc == DATA_W'($past(acc) + $past(opnd)))
        else $error("add result not in accumulator");

endmodule

// ==== testbench/bca_file_model.sv ====
`timescale 1ns/1ps
module bca_file_model import bca_pkg::*; (
    // clock and enable
    input  logic               clk,
    input  logic               ce,
    // file register access from the execute unit
    input  logic [FADDR_W-1:0] file_addr,
    input  logic               file_we,
    input  logic [DATA_W-1:0]  file_wdata,
    output logic [DATA_W-1:0]  file_rdata
);
    logic [DATA_W-1:0] mem [32];

    // read is combinational; the execute unit picks it up at its own edge
    assign file_rdata = mem[file_addr];

    // plain always so the bench may preload cells between edges
    always @(posedge clk) begin
        if (ce && file_we) begin
            mem[file_addr] <= file_wdata;
        end
    end
endmodule

// ==== testbench/tb_baseline_cpu_alu_bit_ops.sv ====
`timescale 1ns/1ps
`define CHK(got, want) begin checked++; if ((got) !== (want)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, (got), (want)); end end
module tb_baseline_cpu_alu_bit_ops import bca_pkg::*;;
    logic                clk, sys_rst, ce, instr_valid, prescaler_on_timer, bus_wr, bus_rd;
    logic                fetch_flush, pc_load, file_we, prescaler_clr;
    logic                carry_flag, digit_carry_flag, zero_flag, d, taken;
    logic [INSTR_W-1:0]  instr_word;
    logic [PAGE_W-1:0]   page_sel;
    logic [1:0]          instr_phase;
    logic [PC_W-1:0]     pc_target;
    logic [FADDR_W-1:0]  file_addr, fa;
    logic [DATA_W-1:0]   file_rdata, file_wdata, port_a_pins, port_b_pins, port_c_pins;
    logic [DATA_W-1:0]   first_io_port_direction_latch_load, bus_wdata, bus_rdata, av, fv, rv, pv, ex;
    logic [BUS_AW-1:0]   bus_addr;
    logic [9:0]          e;
    logic [2:0]          b, fl;
    int                  n_fail, checked, nf, np, nl, i, snap;
    int                  seed = 32'h83AF39DD;

    bca_exec u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .instr_word(instr_word),
        .instr_valid(instr_valid), .page_sel(page_sel), .instr_phase(instr_phase),
        .fetch_flush(fetch_flush), .pc_load(pc_load), .pc_target(pc_target),
        .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
        .file_wdata(file_wdata), .port_a_pins(port_a_pins), .port_b_pins(port_b_pins),
        .port_c_pins(port_c_pins), .first_io_port_direction_latch_load(first_io_port_direction_latch_load),
        .prescaler_on_timer(prescaler_on_timer), .prescaler_clr(prescaler_clr),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

    bca_file_model u_file (.clk(clk), .ce(ce), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .file_rdata(file_rdata));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // pulses last one cycle, so a count per cycle catches each exactly once
    always @(negedge clk) begin
        nf += (fetch_flush === 1'b1);
        np += (prescaler_clr === 1'b1);
        nl += (pc_load === 1'b1);
    end

    task automatic report_and_stop();
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // register port: one-cycle strobes, read data in the following cycle
    task automatic bus_w(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic bus_r(input logic [BUS_AW-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        v = bus_rdata;
    endtask

    // return on the commit edge, so the next word lands on the capture edge
    task automatic sync();
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            if (instr_phase === PH_Q4) begin
                @(posedge clk);
                return;
            end
        end
        n_fail++;
        report_and_stop();
    endtask

    // valid drops after capture; an idle slot then follows unless issued again
    task automatic issue(input logic [INSTR_W-1:0] ir);
        instr_word <= ir;
        instr_valid <= 1'b1;
        page_sel <= PAGE_W'($random(seed));
        @(posedge clk);
        instr_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic run(input logic [INSTR_W-1:0] ir);
        sync();
        issue(ir);
        // one more edge lets the file write-back land before anything is checked
        @(posedge clk);
        @(negedge clk);
    endtask

    function automatic logic [9:0] add_exp(input logic [7:0] x, input logic [7:0] y);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, x} + {1'b0, y};
        h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
        return {s[8], h[4], s[7:0]};
    endfunction

    // hang guard
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        {ce, sys_rst, instr_valid, prescaler_on_timer, bus_wr, bus_rd} = 6'h30;
        {instr_word, page_sel, bus_addr, bus_wdata} = 26'h0;
        {port_a_pins, port_b_pins, port_c_pins} = 24'h0;
        {nf, np, nl, n_fail, checked} = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        `CHK(first_io_port_direction_latch_load, RST_DIR)
        bus_r(REG_ACC, rv);
        `CHK(rv, BYTE_0)
        sync();
        repeat (4) @(negedge clk);
        `CHK(instr_phase, PH_Q4)
        // add with random operands, carry corners first
        for (i = 0; i < 24; i++) begin
            av = i == 0 ? 8'h0F : i == 1 ? 8'hFF : 8'($random(seed));
            fv = i < 2 ? 8'h01 : 8'($random(seed));
            fa = 5'h10 | 5'($random(seed));
            d = i[0];
            u_file.mem[fa] = fv;
            bus_w(REG_ACC, av);
            run({OPC_ADD_ACC_FILE, d, fa});
            e = add_exp(av, fv);
            `CHK({zero_flag, digit_carry_flag, carry_flag}, {e[7:0] == 8'h00, e[8], e[9]})
            `CHK(u_file.mem[fa], d ? e[7:0] : fv)
            bus_r(REG_ACC, rv);
            `CHK(rv, d ? av : e[7:0])
        end
        // and with literal, then with file; carry and digit carry must survive
        for (i = 0; i < 16; i++) begin
            av = 8'($random(seed));
            fv = i[1:0] == 2'h2 ? ~av : 8'($random(seed));
            fa = 5'h10 | 5'($random(seed));
            fl = 3'($random(seed));
            d = i[0];
            ex = av & fv;
            u_file.mem[fa] = fv;
            bus_w(REG_ACC, av);
            bus_w(REG_FLAGS, {5'h00, fl});
            run(i < 8 ? {OPC_AND_LITERAL, fv} : {OPC_AND_ACC_FILE, d, fa});
            `CHK({zero_flag, digit_carry_flag, carry_flag}, {ex == 8'h00, fl[1:0]})
            `CHK(u_file.mem[fa], (i >= 8 && d) ? ex : fv)
            bus_r(REG_ACC, rv);
            `CHK(rv, (i < 8 || !d) ? ex : av)
        end
        // bit clear and set, top bit first
        for (i = 0; i < 16; i++) begin
            fv = 8'($random(seed));
            fa = 5'h10 | 5'($random(seed));
            b = i < 2 ? 3'h7 : 3'($random(seed));
            fl = 3'($random(seed));
            u_file.mem[fa] = fv;
            bus_w(REG_FLAGS, {5'h00, fl});
            run({i[0] ? OPC_BIT_SET : OPC_BIT_CLEAR, b, fa});
            ex = i[0] ? fv | (8'h01 << b) : fv & ~(8'h01 << b);
            `CHK(u_file.mem[fa], ex)
            `CHK({zero_flag, digit_carry_flag, carry_flag}, fl)
            bus_r(REG_FLAGS, rv);
            `CHK(rv, {5'h00, fl})
        end
        // both skips, both bit values; clear-accumulator sits in the shadow slot
        for (i = 0; i < 8; i++) begin
            fv = 8'($random(seed));
            fa = 5'h10 | 5'($random(seed));
            b = 3'($random(seed));
            fv[b] = i[1];
            taken = i[0] == i[1];
            u_file.mem[fa] = fv;
            bus_w(REG_ACC, 8'h5A);
            bus_w(REG_FLAGS, 8'h00);
            snap = nf;
            sync();
            issue({i[0] ? OPC_SKIP_SET : OPC_SKIP_CLEAR, b, fa});
            issue(OPC_CLEAR_ACC);
            @(negedge clk);
            `CHK(nf - snap, taken ? 1 : 0)
            `CHK(zero_flag, !taken)
            bus_r(REG_ACC, rv);
            `CHK(rv, taken ? 8'h5A : BYTE_0)
        end
        // port read-modify-write uses the pins, never the latch
        for (i = 0; i < 3; i++) begin
            pv = 8'($random(seed));
            av = 8'($random(seed));
            @(posedge clk);
            port_a_pins <= pv;
            port_b_pins <= pv ^ 8'h3C;
            port_c_pins <= pv ^ 8'hC3;
            ex = i == 0 ? pv : i == 1 ? pv ^ 8'h3C : pv ^ 8'hC3;
            fa = ADDR_PORT_A + 5'(i);
            u_file.mem[fa] = ~ex;
            bus_w(REG_ACC, av);
            run({OPC_ADD_ACC_FILE, 1'b1, fa});
            `CHK(u_file.mem[fa], av + ex)
        end
        // direction load: other operands ignored, operand 6 copies the accumulator
        av = 8'($random(seed));
        bus_w(REG_ACC, av);
        run({OPC_DIR_LOAD, 3'h5});
        `CHK(first_io_port_direction_latch_load, RST_DIR)
        run({OPC_DIR_LOAD, DIR_SEL_PORT_A});
        `CHK(first_io_port_direction_latch_load, av)
        bus_w(REG_DIR, 8'h00);
        bus_r(REG_DIR, rv);
        `CHK(rv, av)
        bus_r(4'hF, rv);
        `CHK(rv, BYTE_0)
        // a low enable freezes the phase and refuses the bus
        @(posedge clk);
        ce <= 1'b0;
        bus_w(REG_ACC, 8'hA5);
        pv = {6'h00, instr_phase};
        repeat (3) @(negedge clk);
        `CHK(instr_phase, pv[1:0])
        @(posedge clk);
        ce <= 1'b1;
        bus_r(REG_ACC, rv);
        `CHK(rv, av)
        // timer writes clear the prescaler only when it belongs to the timer
        for (i = 0; i < 6; i++) begin
            @(posedge clk);
            prescaler_on_timer <= i[0];
            u_file.mem[ADDR_TIMER] = 8'($random(seed));
            snap = np;
            run(i < 2 ? {OPC_ADD_ACC_FILE, 1'b1, ADDR_TIMER} :
                i < 4 ? {OPC_ADD_ACC_FILE, 1'b0, ADDR_TIMER} : {OPC_BIT_CLEAR, 3'h0, ADDR_TIMER});
            `CHK(np - snap, (i[0] && (i < 2 || i > 3)) ? 1 : 0)
        end
        // counter writes: file write clears bit 8, the jump keeps it
        av = 8'($random(seed));
        fv = 8'($random(seed));
        u_file.mem[ADDR_PC_LOW] = fv;
        bus_w(REG_ACC, av);
        snap = nf;
        run({OPC_ADD_ACC_FILE, 1'b1, ADDR_PC_LOW});
        `CHK(pc_target, {page_sel, 1'b0, 8'(av + fv)})
        `CHK(nf - snap, 1)
        `CHK(nl, 1)
        run({OPC_ABS_JUMP, 1'b1, fv});
        `CHK(pc_target, {page_sel, 1'b1, fv})
        `CHK(nf - snap, 2)
        `CHK(nl, 2)
        report_and_stop();
    end
endmodule
